// file: hdl/accessory_irq_regs.sv
// Accessory interrupt registers and HS tuning register
`timescale 1ns/1ps
module accessory_irq_regs #(
   parameter int unsigned CONV_CYCLES = accessory_pkg::CONV_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic id_float_raw_i,
   input wire logic dataline_cmp_raw_i,
   input wire logic id_pullup_enable_i,
   input wire logic current_sink_enable_i,
   input wire logic [2:0] conv_result_i,
   output logic conv_start_o,
   output logic alt_int_o,
   output logic [1:0] squelch_threshold_scale_o,
   output logic [2:0] hs_tx_amplitude_boost_o
);
   logic [7:0] accessory_irq_enable;
   logic [7:0] accessory_irq_latch;
   logic [7:0] hs_signal_tuning;
   logic [7:0] rconv_ctrl;
   logic [2:0] resistor_conv_result;
   logic resistor_conv_done;
   logic id_float_prev;
   logic dataline_prev;
   logic [7:0] rd_addr_q;
   logic conv_done_pulse;
   logic conv_busy;

   // Pin synchronisers, a change counts once stages two and three agree
   wire [1:0] raw_in = {dataline_cmp_raw_i, id_float_raw_i};
   logic [1:0] sync1;
   logic [1:0] sync2;
   logic [1:0] sync3;
   logic [1:0] filt;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_sync
         always_ff @(posedge core_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
               sync3[g] <= 1'b0;
               filt[g] <= 1'b0;
            end
            else
            begin
               sync1[g] <= raw_in[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
               if (sync2[g] == sync3[g])
                  filt[g] <= sync3[g];
            end
         end
      end
   endgenerate

   // Both levels are only meaningful with their analog helper enabled
   wire id_pin_floating = filt[0] & id_pullup_enable_i;
   wire dataline_voltage_seen = filt[1] & current_sink_enable_i;

   // Address decode
   wire wr_enable = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_IRQ_ENABLE);
   wire wr_enable_set = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_IRQ_ENABLE_SET);
   wire wr_enable_clr = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_IRQ_ENABLE_CLR);
   wire wr_tuning = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_HS_TUNING);
   wire wr_rconv = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_RCONV);
   wire wr_rconv_set = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_RCONV_SET);
   wire wr_rconv_clr = reg_wr_i && (reg_addr_i == accessory_pkg::ADDR_RCONV_CLR);
   wire rd_latch = reg_rd_i && (reg_addr_i == accessory_pkg::ADDR_IRQ_LATCH);
   wire rd_rconv = reg_rd_i && (reg_addr_i >= accessory_pkg::ADDR_RCONV)
                   && (reg_addr_i <= accessory_pkg::ADDR_RCONV_CLR);

   // Enable register with write, set and clear aliases
   wire [7:0] en_wval = reg_wdata_i & accessory_pkg::ENABLE_MASK;
   wire [7:0] next_irq_enable = wr_enable ? en_wval
                              : wr_enable_set ? (accessory_irq_enable | en_wval)
                              : wr_enable_clr ? (accessory_irq_enable & ~en_wval)
                              : accessory_irq_enable;

   // Vendor conversion control, result and done are read-only there
   wire [7:0] rc_wval = reg_wdata_i & accessory_pkg::RCONV_WR_MASK;
   wire [7:0] rconv_written = wr_rconv ? rc_wval
                            : wr_rconv_set ? (rconv_ctrl | rc_wval)
                            : wr_rconv_clr ? (rconv_ctrl & ~rc_wval)
                            : rconv_ctrl;
   wire [7:0] start_clear = 8'(conv_done_pulse) << accessory_pkg::RCONV_START_BIT;
   wire [7:0] next_rconv_ctrl = rconv_written & ~start_clear;

   wire [7:0] next_tuning = wr_tuning ? (reg_wdata_i & accessory_pkg::TUNING_MASK)
                          : hs_signal_tuning;

   // Event detection
   wire id_rise = id_pin_floating & ~id_float_prev;
   wire id_fall = ~id_pin_floating & id_float_prev;
   wire ev_id = (id_rise & accessory_irq_enable[accessory_pkg::EN_ID_ON_BIT])
              | (id_fall & accessory_irq_enable[accessory_pkg::EN_ID_OFF_BIT]);
   wire ev_dataline = (dataline_voltage_seen ^ dataline_prev)
                    & accessory_irq_enable[accessory_pkg::EN_DATALINE_BIT];
   wire resistor_conv_irq_enable = accessory_irq_enable[accessory_pkg::EN_RCONV_BIT]
                                 | rconv_ctrl[accessory_pkg::RCONV_IRQ_EN_BIT];
   wire done_rise = conv_done_pulse & ~resistor_conv_done;
   wire resistor_conv_event = done_rise & resistor_conv_irq_enable;

   wire [7:0] latch_events = (8'(ev_id) << accessory_pkg::LT_ID_BIT)
                           | (8'(ev_dataline) << accessory_pkg::LT_DATALINE_BIT)
                           | (8'(resistor_conv_event) << accessory_pkg::LT_RCONV_BIT);
   // New events are ORed after the read clear so none is lost
   wire [7:0] next_latch = (rd_latch ? accessory_pkg::LATCH_RESET : accessory_irq_latch)
                         | latch_events;

   // Done sets on finish; a finish in the clearing cycle still sets
   wire next_done = (resistor_conv_done & ~rd_rconv) | conv_done_pulse;

   // Read views
   wire [7:0] status_byte = (8'(id_pin_floating) << accessory_pkg::ST_ID_FLOAT_BIT)
                          | (8'(dataline_voltage_seen) << accessory_pkg::ST_DATALINE_BIT)
                          | (8'(resistor_conv_result) << accessory_pkg::ST_RESULT_LSB)
                          | (8'(resistor_conv_done) << accessory_pkg::ST_DONE_BIT);
   wire [7:0] rconv_byte = (rconv_ctrl & accessory_pkg::RCONV_WR_MASK)
                         | (8'(resistor_conv_done) << accessory_pkg::RCONV_DONE_BIT)
                         | 8'(resistor_conv_result);
   logic [7:0] rd_mux;

   always_comb
   begin
      case (reg_addr_i)
         accessory_pkg::ADDR_IRQ_ENABLE,
         accessory_pkg::ADDR_IRQ_ENABLE_SET,
         accessory_pkg::ADDR_IRQ_ENABLE_CLR: rd_mux = accessory_irq_enable;
         accessory_pkg::ADDR_IRQ_STATUS: rd_mux = status_byte;
         accessory_pkg::ADDR_IRQ_LATCH: rd_mux = accessory_irq_latch;
         accessory_pkg::ADDR_HS_TUNING: rd_mux = hs_signal_tuning;
         accessory_pkg::ADDR_RCONV,
         accessory_pkg::ADDR_RCONV_SET,
         accessory_pkg::ADDR_RCONV_CLR: rd_mux = rconv_byte;
         // Rest of the vendor space and anything else reads zero
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         accessory_irq_enable <= accessory_pkg::ENABLE_RESET;
         accessory_irq_latch <= accessory_pkg::LATCH_RESET;
         hs_signal_tuning <= accessory_pkg::TUNING_RESET;
         rconv_ctrl <= accessory_pkg::RCONV_RESET;
         resistor_conv_result <= accessory_pkg::RESULT_RESET;
         resistor_conv_done <= 1'b0;
         id_float_prev <= 1'b0;
         dataline_prev <= 1'b0;
      end
      else
      begin
         accessory_irq_enable <= next_irq_enable;
         accessory_irq_latch <= next_latch;
         hs_signal_tuning <= next_tuning;
         rconv_ctrl <= next_rconv_ctrl;
         if (conv_done_pulse)
            resistor_conv_result <= conv_result_i;
         resistor_conv_done <= next_done;
         id_float_prev <= id_pin_floating;
         dataline_prev <= dataline_voltage_seen;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
         rd_addr_q <= 8'h00;
      end
      else
      begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
         reg_rvalid_o <= reg_rd_i;
         rd_addr_q <= reg_addr_i;
      end
   end

   conv_timer #(
      .CYCLES(CONV_CYCLES)
   ) u_conv_timer (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(rconv_ctrl[accessory_pkg::RCONV_START_BIT]),
      .done_o(conv_done_pulse),
      .busy_o(conv_busy)
   );

   assign conv_start_o = rconv_ctrl[accessory_pkg::RCONV_START_BIT];
   // Level held while any latched event is pending
   assign alt_int_o = |accessory_irq_latch;
   assign squelch_threshold_scale_o = hs_signal_tuning[accessory_pkg::TUNING_SQUELCH_LSB +: 2];
   assign hs_tx_amplitude_boost_o = hs_signal_tuning[accessory_pkg::TUNING_BOOST_LSB +: 3];

   // Checks
   localparam int unsigned HW = $clog2(CONV_CYCLES + 2);
   logic [HW-1:0] busy_len;

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         busy_len <= '0;
      else
         busy_len <= conv_busy ? busy_len + 1'b1 : '0;
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_conv_begin;
      !conv_start_o ##1 conv_start_o;
   endsequence

   sequence s_quiet_start;
      !conv_done_pulse [*8];
   endsequence

   sequence s_rd_valid(logic [7:0] a);
      reg_rvalid_o && (rd_addr_q == a);
   endsequence

   a_conv_not_early: assert property (s_conv_begin |-> s_quiet_start)
      else $error("conversion finished too early");

   a_conv_exact_len: assert property (conv_done_pulse |-> busy_len == HW'(CONV_CYCLES))
      else $error("conversion length wrong");

   a_rconv_irq_latch: assert property (done_rise && resistor_conv_irq_enable
      |=> accessory_irq_latch[accessory_pkg::LT_RCONV_BIT] ##0 alt_int_o)
      else $error("conversion interrupt missing");

   a_vendor_enable_or: assert property (done_rise && rconv_ctrl[accessory_pkg::RCONV_IRQ_EN_BIT]
      && !accessory_irq_enable[accessory_pkg::EN_RCONV_BIT]
      |=> accessory_irq_latch[accessory_pkg::LT_RCONV_BIT])
      else $error("vendor enable not honoured");

   a_unused_read_zero: assert property (s_rd_valid(accessory_pkg::ADDR_IRQ_ENABLE)
      |-> reg_rdata_o[4:3] == 2'b00 && reg_rdata_o[7:6] == 2'b00)
      else $error("unused enable bits not zero");

   a_status_live: assert property (reg_rd_i && reg_addr_i == accessory_pkg::ADDR_IRQ_STATUS
      |=> reg_rdata_o == $past(status_byte) && reg_rdata_o[7] == 1'b0)
      else $error("status read mismatch");

   a_dataline_gated: assert property (!current_sink_enable_i |-> !dataline_voltage_seen)
      else $error("comparator shown without sink");

   a_result_capture: assert property (conv_done_pulse
      |=> resistor_conv_result == $past(conv_result_i) && resistor_conv_done)
      else $error("result not captured");

   a_done_cleared: assert property (rd_rconv && !conv_done_pulse |=> !resistor_conv_done)
      else $error("done not cleared by vendor read");

   a_status_keeps_done: assert property (reg_rd_i && reg_addr_i == accessory_pkg::ADDR_IRQ_STATUS
      && resistor_conv_done |=> resistor_conv_done)
      else $error("status read cleared done");

   a_latch_read_clear: assert property (rd_latch && latch_events == 8'h00
      |=> accessory_irq_latch == 8'h00 && !alt_int_o)
      else $error("latch not cleared on read");

   a_id_edge_latch: assert property (ev_id |=> accessory_irq_latch[accessory_pkg::LT_ID_BIT])
      else $error("ID edge not latched");

   a_dataline_latch: assert property ($changed(dataline_voltage_seen)
      && accessory_irq_enable[accessory_pkg::EN_DATALINE_BIT]
      |=> accessory_irq_latch[accessory_pkg::LT_DATALINE_BIT])
      else $error("comparator change not latched");

   a_latch_high_zero: assert property (accessory_irq_latch[7:4] == 4'h0
      && accessory_irq_latch[2] == 1'b0)
      else $error("latch reserved bits set");

   a_vendor_hole_zero: assert property (reg_rvalid_o && rd_addr_q >= accessory_pkg::ADDR_VENDOR_FIRST
      && rd_addr_q <= accessory_pkg::ADDR_VENDOR_LAST && rd_addr_q != accessory_pkg::ADDR_HS_TUNING
      && (rd_addr_q < accessory_pkg::ADDR_RCONV || rd_addr_q > accessory_pkg::ADDR_RCONV_CLR)
      |-> reg_rdata_o == 8'h00)
      else $error("unmapped vendor address not zero");

   a_tuning_write: assert property (wr_tuning |=> squelch_threshold_scale_o == $past(reg_wdata_i[1:0])
      && hs_tx_amplitude_boost_o == $past(reg_wdata_i[6:4])
      && (hs_signal_tuning & ~accessory_pkg::TUNING_MASK) == 8'h00)
      else $error("tuning write not applied");

   a_id_float_enable: assert property (id_rise && !accessory_irq_enable[accessory_pkg::EN_ID_ON_BIT]
      && !rd_latch |=> $stable(accessory_irq_latch[accessory_pkg::LT_ID_BIT]))
      else $error("ID rise latched while disabled");

   a_latch_race: assert property (rd_latch && ev_id |=> accessory_irq_latch[accessory_pkg::LT_ID_BIT])
      else $error("event lost on latch read");

   a_id_fall_enable: assert property (id_fall && !accessory_irq_enable[accessory_pkg::EN_ID_OFF_BIT]
      && !rd_latch |=> $stable(accessory_irq_latch[accessory_pkg::LT_ID_BIT]))
      else $error("ID fall latched while disabled");

   a_start_self_clear: assert property (conv_done_pulse |=> !conv_start_o)
      else $error("start bit not cleared at finish");

   a_rvalid_follows: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read answer missing");

   a_rdata_idle_zero: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
      else $error("read data not zero when idle");

   a_enable_mask: assert property ((accessory_irq_enable & ~accessory_pkg::ENABLE_MASK) == 8'h00)
      else $error("unused enable bits stored");
endmodule : accessory_irq_regs

// file: hdl/accessory_pkg.sv
// Constants for the accessory interrupt and HS tuning registers
package accessory_pkg;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1d;
   localparam logic [7:0] ADDR_IRQ_ENABLE_SET = 8'h1e;
   localparam logic [7:0] ADDR_IRQ_ENABLE_CLR = 8'h1f;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_LATCH = 8'h21;
   localparam logic [7:0] ADDR_VENDOR_FIRST = 8'h30;
   localparam logic [7:0] ADDR_VENDOR_LAST = 8'h3f;
   localparam logic [7:0] ADDR_HS_TUNING = 8'h31;
   localparam logic [7:0] ADDR_RCONV = 8'h36;
   localparam logic [7:0] ADDR_RCONV_SET = 8'h37;
   localparam logic [7:0] ADDR_RCONV_CLR = 8'h38;

   localparam int unsigned EN_ID_ON_BIT = 0;
   localparam int unsigned EN_ID_OFF_BIT = 1;
   localparam int unsigned EN_DATALINE_BIT = 2;
   localparam int unsigned EN_RCONV_BIT = 5;
   localparam logic [7:0] ENABLE_MASK = 8'h27;

   localparam int unsigned ST_ID_FLOAT_BIT = 0;
   localparam int unsigned ST_DATALINE_BIT = 1;
   localparam int unsigned ST_RESULT_LSB = 3;
   localparam int unsigned ST_DONE_BIT = 6;

   localparam int unsigned LT_ID_BIT = 0;
   localparam int unsigned LT_DATALINE_BIT = 1;
   localparam int unsigned LT_RCONV_BIT = 3;

   localparam logic [7:0] TUNING_MASK = 8'h73;
   localparam int unsigned TUNING_SQUELCH_LSB = 0;
   localparam int unsigned TUNING_BOOST_LSB = 4;

   localparam int unsigned RCONV_DONE_BIT = 3;
   localparam int unsigned RCONV_START_BIT = 4;
   localparam int unsigned RCONV_IRQ_EN_BIT = 6;
   localparam logic [7:0] RCONV_WR_MASK = 8'h50;

   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] TUNING_RESET = 8'h00;
   localparam logic [7:0] RCONV_RESET = 8'h00;
   localparam logic [2:0] RESULT_RESET = 3'h0;

   localparam int unsigned CONV_TIME_US = 282;
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned CONV_CYCLES = (CONV_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b01,
      CONV_BUSY = 2'b10
   } conv_state_e;
endpackage : accessory_pkg

// file: hdl/conv_timer.sv
// Resistor conversion interval timer
`timescale 1ns/1ps
module conv_timer #(
   parameter int unsigned CYCLES = accessory_pkg::CONV_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   output logic done_o,
   output logic busy_o
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   accessory_pkg::conv_state_e state;
   accessory_pkg::conv_state_e next_state;
   logic [CW-1:0] count;
   wire at_last = (count == LAST);

   always_comb
   begin
      next_state = state;
      case (state)
         accessory_pkg::CONV_IDLE:
            // Start is still high in the done cycle, so it must not re-arm there
            if (start_i && !done_o)
               next_state = accessory_pkg::CONV_BUSY;
         accessory_pkg::CONV_BUSY:
            // Dropping start aborts without a done pulse
            if (!start_i || at_last)
               next_state = accessory_pkg::CONV_IDLE;
         default:
            next_state = accessory_pkg::CONV_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state <= accessory_pkg::CONV_IDLE;
         count <= '0;
         done_o <= 1'b0;
      end
      else
      begin
         state <= next_state;
         count <= (state == accessory_pkg::CONV_BUSY && !at_last) ? count + 1'b1 : '0;
         done_o <= (state == accessory_pkg::CONV_BUSY) && start_i && at_last;
      end
   end

   assign busy_o = (state == accessory_pkg::CONV_BUSY);
endmodule : conv_timer

// file: test/testbench.sv
// Self-checking bench for the accessory interrupt and tuning registers
`timescale 1ns/1ps
module testbench;
   localparam int unsigned CONV_N = 20;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, conv_start, alt_int, rd_ok;
   logic id_float_raw = 1'b0;
   logic dataline_cmp_raw = 1'b0;
   logic id_pullup_enable = 1'b0;
   logic current_sink_enable = 1'b0;
   logic [2:0] conv_result = 3'h0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_data, v;
   logic [1:0] squelch;
   logic [2:0] boost, res;
   logic [2:0] res_q = 3'h0;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   int seed = 32'hea6d6150;
   int m_en = 0;

   always #4 core_clk = ~core_clk;

   ulpi_link_model link (.core_clk_i(core_clk), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid));

   accessory_irq_regs #(.CONV_CYCLES(CONV_N)) uut (.core_clk_i(core_clk), .rst_n_i(rst_n), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
      .reg_rvalid_o(reg_rvalid), .id_float_raw_i(id_float_raw), .dataline_cmp_raw_i(dataline_cmp_raw),
      .id_pullup_enable_i(id_pullup_enable), .current_sink_enable_i(current_sink_enable),
      .conv_result_i(conv_result), .conv_start_o(conv_start), .alt_int_o(alt_int),
      .squelch_threshold_scale_o(squelch), .hs_tx_amplitude_boost_o(boost));

   task automatic conclude;
      if (err_count == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t: register read %h, expected %h", $time, got, exp);
      end
   endtask : check_byte

   task automatic check_out(input logic [2:0] got, input logic [2:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t: output %h, expected %h", $time, got, exp);
      end
   endtask : check_out

   task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
      link.read_reg(addr, rd_data, rd_ok);
      check_out({2'b00, rd_ok}, 3'h1);
      check_byte(rd_data, exp);
   endtask : read_check

   // Sync chain plus one event cycle, with margin
   task automatic settle;
      repeat (6) @(negedge core_clk);
   endtask : settle

   // Run away guard, far above the expected run length
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         conclude();
      end
   end

   initial
   begin
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      read_check(accessory_pkg::ADDR_IRQ_ENABLE, 8'h00);
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h00);
      read_check(accessory_pkg::ADDR_HS_TUNING, 8'h00);
      check_out({2'b00, alt_int}, 3'h0);
      // Every squelch and boost code with random reserved bits
      for (int i = 0; i < 32; i++)
      begin
         v = 8'($random(seed));
         v[1:0] = i[1:0];
         v[6:4] = i[4:2];
         link.write_reg(accessory_pkg::ADDR_HS_TUNING, v);
         read_check(accessory_pkg::ADDR_HS_TUNING, v & 8'h73);
         check_out({1'b0, squelch}, {1'b0, v[1:0]});
         check_out(boost, v[6:4]);
      end
      // Mid-run reset brings tuning back to its defaults
      rst_n = 1'b0;
      @(negedge core_clk);
      rst_n = 1'b1;
      read_check(accessory_pkg::ADDR_HS_TUNING, 8'h00);
      check_out(boost, 3'h0);
      link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE, 8'hff);
      read_check(accessory_pkg::ADDR_IRQ_ENABLE_SET, 8'h27);
      link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE_CLR, 8'hfe);
      m_en = 'h01;
      read_check(accessory_pkg::ADDR_IRQ_ENABLE_CLR, 8'(m_en));
      link.write_reg(accessory_pkg::ADDR_IRQ_STATUS, 8'hff);
      link.write_reg(accessory_pkg::ADDR_IRQ_LATCH, 8'hff);
      read_check(accessory_pkg::ADDR_IRQ_STATUS, 8'h00);
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h00);
      // ID pin goes floating with only the float-on enable armed
      id_pullup_enable = 1'b1;
      id_float_raw = 1'b1;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_STATUS, 8'h01);
      check_out({2'b00, alt_int}, 3'h1);
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h01);
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h00);
      check_out({2'b00, alt_int}, 3'h0);
      id_float_raw = 1'b0;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h00);
      // Swap to the float-off enable
      link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE_CLR, 8'h01);
      link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE_SET, 8'h02);
      m_en = 'h02;
      id_float_raw = 1'b1;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h00);
      id_float_raw = 1'b0;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h01);
      // Comparator changes in both directions
      link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE_SET, 8'h04);
      m_en = m_en | 'h04;
      read_check(accessory_pkg::ADDR_IRQ_ENABLE, 8'(m_en));
      current_sink_enable = 1'b1;
      dataline_cmp_raw = 1'b1;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_STATUS, 8'h02);
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h02);
      dataline_cmp_raw = 1'b0;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_LATCH, 8'h02);
      current_sink_enable = 1'b0;
      dataline_cmp_raw = 1'b1;
      settle();
      read_check(accessory_pkg::ADDR_IRQ_STATUS, 8'h00);
      // Conversions: carkit enable, vendor enable, then neither
      link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE, 8'h20);
      for (int k = 0; k < 3; k++)
      begin
         res = 3'($random(seed));
         conv_result = res;
         if (k == 1)
         begin
            link.write_reg(accessory_pkg::ADDR_IRQ_ENABLE, 8'h00);
            link.write_reg(accessory_pkg::ADDR_RCONV, 8'h40);
         end
         if (k == 2)
            link.write_reg(accessory_pkg::ADDR_RCONV, 8'h00);
         link.write_reg(accessory_pkg::ADDR_RCONV_SET, 8'h10);
         check_out({2'b00, conv_start}, 3'h1);
         // Last edge before done; result field still holds the previous conversion
         repeat (CONV_N - 1) @(negedge core_clk);
         read_check(accessory_pkg::ADDR_IRQ_STATUS, {2'b00, res_q, 3'h0});
         read_check(accessory_pkg::ADDR_IRQ_STATUS, {2'b01, res, 3'h0});
         read_check(accessory_pkg::ADDR_IRQ_STATUS, {2'b01, res, 3'h0});
         check_out({2'b00, alt_int}, {2'b00, k < 2});
         read_check(accessory_pkg::ADDR_IRQ_LATCH, (k < 2) ? 8'h08 : 8'h00);
         read_check(accessory_pkg::ADDR_RCONV, {1'b0, k == 1, 3'b001, res});
         read_check(accessory_pkg::ADDR_IRQ_STATUS, {2'b00, res, 3'h0});
         check_out({2'b00, conv_start}, 3'h0);
         res_q = res;
      end
      // Unused vendor space ignores writes and reads zero
      link.write_reg(8'h3a, 8'hff);
      read_check(8'h3a, 8'h00);
      read_check(accessory_pkg::ADDR_VENDOR_FIRST, 8'h00);
      conclude();
   end
endmodule : testbench

// file: test/ulpi_link_model.sv
// Link-side model issuing immediate register reads and writes
`timescale 1ns/1ps
module ulpi_link_model (
   input wire logic core_clk_i,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i
);
   initial
   begin
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end

   // Immediate write only; lines inverted afterwards so stale values never pass for valid
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge core_clk_i);
      reg_wr_o = 1'b1;
      reg_addr_o = addr;
      reg_wdata_o = data;
      @(negedge core_clk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~addr;
      reg_wdata_o = ~data;
   endtask : write_reg

   // Immediate read; answer stands only the cycle after the strobe, so take it there
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
      @(negedge core_clk_i);
      reg_rd_o = 1'b1;
      reg_addr_o = addr;
      @(negedge core_clk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~addr;
      data = reg_rdata_i;
      valid = reg_rvalid_i;
   endtask : read_reg
endmodule : ulpi_link_model
